// >>> src/irc_top.sv
// Interrupt request control with APB register access
`timescale 1ns/1ns
module irc_top
  import irc_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  ext_pin,
  input  wire logic [1:0]  time_base_evt,
  input  wire logic        serial_iface_evt,
  input  wire logic        serial_port_evt,
  input  wire logic [1:0]  compact_timer_evt,
  input  wire logic [1:0]  std_timer_evt,
  input  wire logic [3:0]  periodic_timer_evt,
  input  wire logic        low_voltage_evt,
  input  wire logic        nvm_data_evt,
  output logic             core_irq_req,
  output logic             irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]       edge_sel;
  logic [7:0]       ctrl0;
  logic [7:0]       ctrl1;
  logic [7:0]       ctrl2;
  logic [7:0]       group0;
  logic [7:0]       group1;
  logic [7:0]       group2;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [7:0] wbyte;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  always_comb begin
    case (paddr)
      ADDR_EDGE_SEL,
      ADDR_CTRL0,
      ADDR_CTRL1,
      ADDR_CTRL2,
      ADDR_GROUP0,
      ADDR_GROUP1,
      ADDR_GROUP2,
      ADDR_STATUS,
      ADDR_CLEAR,
      ADDR_ENABLE: addr_ok = 1'b1;
      default:     addr_ok = 1'b0;
    endcase
  end

  // Variant masks: the small variant lacks serial port and upper timers
  logic [7:0] mask_ctrl2;
  logic [7:0] mask_grp01;
  assign mask_ctrl2 = FULL_VARIANT ? MASK_CTRL2 : 8'h11;
  assign mask_grp01 = FULL_VARIANT ? MASK_FULL : MASK_HALF;

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [1:0] pin_edge;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Low like idle pins, so no false edge after reset
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= ext_pin; // see [R13]
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // One detector per pin, coding shared by both fields
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic [1:0] sel;
      assign sel = edge_sel[POS_PIN0_SEL + 2*gi +: 2]; // see [R3] see [R4]
      always_comb begin
        case (sel)
          EDGE_RISE: pin_edge[gi] = pin_sync[gi] & ~pin_prev[gi];
          EDGE_FALL: pin_edge[gi] = ~pin_sync[gi] & pin_prev[gi];
          EDGE_BOTH: pin_edge[gi] = pin_sync[gi] ^ pin_prev[gi];
          default:   pin_edge[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------
  // Edge select register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      edge_sel <= RST_REG; // see [R5]
    end else if (wr_en && paddr == ADDR_EDGE_SEL) begin
      // Upper bits are not stored, so they read zero
      edge_sel <= wbyte & MASK_EDGE_SEL; // see [R10] see [R5]
    end
  end

  // ----------------------------------------
  // Flag set logic: set wins over software write
  // ----------------------------------------
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] gset0;
  logic [7:0] gset1;
  logic [7:0] gset2;
  logic [2:0] grp_pend;
  // Each vector lines up with its register: flags in 7:4, enables zero
  assign set0 = {
    1'b0,
    time_base_evt[0],
    pin_edge[1],
    pin_edge[0], // see [R11]
    4'h0
  };
  assign gset0 = {
    std_timer_evt[1],
    std_timer_evt[0],
    compact_timer_evt[1],
    compact_timer_evt[0],
    4'h0
  };
  assign gset1 = {
    periodic_timer_evt[3],
    periodic_timer_evt[2],
    periodic_timer_evt[1],
    periodic_timer_evt[0],
    4'h0
  };
  assign gset2 = {
    2'h0,
    nvm_data_evt,
    low_voltage_evt,
    4'h0
  };
  assign set2 = {
    2'h0,
    serial_port_evt,
    serial_iface_evt, // see [R2]
    4'h0
  };
  // Group pending: any enabled member flag
  assign grp_pend[0] = |(group0[7:4] & group0[3:0]);
  assign grp_pend[1] = |(group1[7:4] & group1[3:0]);
  assign grp_pend[2] = |(group2[7:4] & group2[3:0]); // see [R8]
  // Group flag is a level copy: it returns while a member stays pending
  assign set1 = {
    grp_pend[2],
    grp_pend[1],
    grp_pend[0],
    time_base_evt[1],
    4'h0
  };

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl0 <= RST_REG;
    end else if (wr_en && paddr == ADDR_CTRL0) begin
      // A written zero clears; a same-cycle event still sets
      ctrl0 <= (wbyte | set0) & MASK_CTRL0; // see [R6] see [R9]
    end else begin
      ctrl0 <= ctrl0 | set0; // see [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl1 <= RST_REG;
    end else if (wr_en && paddr == ADDR_CTRL1) begin
      ctrl1 <= wbyte | set1; // see [R7]
    end else begin
      ctrl1 <= ctrl1 | set1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl2 <= RST_REG;
    end else if (wr_en && paddr == ADDR_CTRL2) begin
      ctrl2 <= (wbyte | set2) & mask_ctrl2;
    end else begin
      ctrl2 <= (ctrl2 | set2) & mask_ctrl2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      group0 <= RST_REG;
    end else if (wr_en && paddr == ADDR_GROUP0) begin
      group0 <= (wbyte | gset0) & mask_grp01; // see [R8]
    end else begin
      group0 <= (group0 | gset0) & mask_grp01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      group1 <= RST_REG;
    end else if (wr_en && paddr == ADDR_GROUP1) begin
      group1 <= (wbyte | gset1) & mask_grp01;
    end else begin
      group1 <= (group1 | gset1) & mask_grp01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      group2 <= RST_REG;
    end else if (wr_en && paddr == ADDR_GROUP2) begin
      group2 <= (wbyte | gset2) & MASK_HALF;
    end else begin
      group2 <= (group2 | gset2) & MASK_HALF;
    end
  end

  // ----------------------------------------
  // Request to the core
  // ----------------------------------------
  logic next_core_req;
  logic primary_pend;
  logic ctrl0_pend;
  logic ctrl1_pend;
  logic ctrl2_pend;
  // Per-register pending, then gated by the global enable
  assign ctrl0_pend   = |(ctrl0[6:4] & ctrl0[3:1]);
  assign ctrl1_pend   = |(ctrl1[7:4] & ctrl1[3:0]);
  assign ctrl2_pend   = |(ctrl2[7:4] & ctrl2[3:0]);
  assign primary_pend = ctrl0_pend | ctrl1_pend | ctrl2_pend; // see [R12]
  assign next_core_req = ctrl0[POS_GLOBAL_EN] & primary_pend; // see [R12]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_irq_req <= 1'b0;
    end else begin
      core_irq_req <= next_core_req; // see [R1]
    end
  end

  // ----------------------------------------
  // Summary event status, clear and enable
  // ----------------------------------------
  logic [EVT_W-1:0] evt_set;
  // Core request bit marks the rise only, not the level
  assign evt_set = {
    |grp_pend,
    next_core_req & ~core_irq_req,
    pin_edge
  };

  always_ff @(posedge clk) begin
    if (!rstn) begin
      evt_status <= '0;
    end else if (wr_en && paddr == ADDR_CLEAR) begin
      // New events win over a simultaneous clear
      evt_status <= (evt_status & ~pwdata[EVT_W-1:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      evt_enable <= '0;
    end else if (wr_en && paddr == ADDR_ENABLE) begin
      // Enable only masks the pin, status still records
      evt_enable <= pwdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      // Registered level, held until the status bit is cleared or its enable bit is written to zero
      irq <= |(evt_status & evt_enable);
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr)
      ADDR_EDGE_SEL: rd_byte = edge_sel;
      ADDR_CTRL0:    rd_byte = ctrl0;
      ADDR_CTRL1:    rd_byte = ctrl1;
      ADDR_CTRL2:    rd_byte = ctrl2;
      ADDR_GROUP0:   rd_byte = group0;
      ADDR_GROUP1:   rd_byte = group1;
      ADDR_GROUP2:   rd_byte = group2;
      ADDR_STATUS:   rd_byte = {4'h0, evt_status};
      ADDR_ENABLE:   rd_byte = {4'h0, evt_enable};
      // Clear register is write-only and reads zero
      default:       rd_byte = 8'h00;
    endcase
  end

  // One wait state keeps every output registered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= {24'h00_0000, rd_byte};
      // Unmapped offsets answer with an error, writes ignored
      pslverr <= ~addr_ok;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end
endmodule

// >>> src/irc_pkg.sv
// Package: register map, field positions and reset values of the interrupt block
// How it works
// [R1] An enabled pending request raises the core interrupt request so the main program is suspended.
// [R2] Requests come from two external pins and from timers, low voltage, data memory, serial, port and time bases.
// [R3] Pin 0 edge field in bits 1..0: 00 off, 01 rising, 10 falling, 11 both.
// [R4] Pin 1 edge field in bits 3..2 uses the same coding, 11 selecting both edges.
// [R5] Edge register bits 7..4 read zero and both edge fields reset to zero.
// [R6] Hardware sets a source flag on its event; software sets the enables.
// [R7] Three primary control registers hold the enables and flags of the primary sources.
// [R8] Three grouped sources each have their own register plus a group enable and flag.
// [R9] Every source has one enable and one flag; the global control has only an enable.
// [R10] A separate register selects the external pin trigger edges.
// [R11] The pin 0 request flag sits in bit 4 of primary control 0, one meaning pending.
// [R12] A request reaches the core only with its enable and the global enable, and group enable.
// [R13] Pin levels are synchronised before edge detection; each selected edge sets the flag once.
package irc_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_EDGE_SEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL0    = 8'h04;
  localparam logic [7:0] ADDR_CTRL1    = 8'h08;
  localparam logic [7:0] ADDR_CTRL2    = 8'h0c;
  localparam logic [7:0] ADDR_GROUP0   = 8'h10;
  localparam logic [7:0] ADDR_GROUP1   = 8'h14;
  localparam logic [7:0] ADDR_GROUP2   = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_CLEAR    = 8'h20;
  localparam logic [7:0] ADDR_ENABLE   = 8'h24;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] MASK_EDGE_SEL = 8'h0f;
  localparam logic [7:0] MASK_CTRL0    = 8'h7f;
  localparam logic [7:0] MASK_CTRL2    = 8'h33;
  localparam logic [7:0] MASK_HALF     = 8'h33;
  localparam logic [7:0] MASK_FULL     = 8'hff;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_PIN0_SEL   = 0;
  localparam int POS_PIN1_SEL   = 2;
  localparam int POS_GLOBAL_EN  = 0;
  localparam int POS_PIN0_EN    = 1;
  localparam int POS_TB0_EN     = 3;
  localparam int POS_PIN0_FLAG  = 4;
  localparam int POS_TB0_FLAG   = 6;
  localparam int POS_TB1_EN     = 0;
  localparam int POS_GRP_EN     = 1;
  localparam int POS_TB1_FLAG   = 4;
  localparam int POS_GRP_FLAG   = 5;
  localparam int FLAG_OFS       = 4;

  // Event status bits of the summary register
  localparam int EVT_W          = 4;
  localparam int EVT_PIN0       = 0;
  localparam int EVT_PIN1       = 1;
  localparam int EVT_CORE_REQ   = 2;
  localparam int EVT_GROUP      = 3;

  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// >>> verification/irc_top_props.sv
// Checker: bus timing and request gating assertions of the interrupt block
`timescale 1ns/1ns
module irc_top_props
  import irc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        core_irq_req,
  input wire logic        irq
);
  // ------
  // Shadows
  // ------
  logic [7:0] edge_sh;
  logic       glob_sh;
  logic [3:0] en_sh;
  logic       done_w;
  assign done_w = psel && penable && pready && pwrite;
  // Follow completed writes only, the design may update one edge earlier
  always_ff @(posedge clk) begin
    if (!rstn) begin
      edge_sh <= 8'h00;
      glob_sh <= 1'b0;
      en_sh   <= 4'h0;
    end else if (done_w) begin
      if (paddr == ADDR_EDGE_SEL) edge_sh <= pwdata[7:0] & MASK_EDGE_SEL;
      if (paddr == ADDR_CTRL0) glob_sh <= pwdata[0];
      if (paddr == ADDR_ENABLE) en_sh <= pwdata[3:0];
    end
  end
  // ------
  // Assertions
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RDY_CAUSE: assert property (pready |->
    $past(psel && penable)) else $error("pready without access");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RDY_WAIT: assert property (psel && penable && !pready |=>
    pready) else $error("pready late");
  AST_RD_IDLE: assert property (!pready |->
    prdata == 32'h0000_0000) else $error("read data outside answer");
  AST_UNMAPPED: assert property (pready && paddr > ADDR_ENABLE |->
    pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
  AST_EDGE_RB: assert property (pready && !pwrite &&
    paddr == ADDR_EDGE_SEL |-> prdata == {24'h00_0000, edge_sh})
    else $error("edge select readback wrong");
  AST_CORE_GATE: assert property (!glob_sh && !$past(glob_sh)
    |-> !core_irq_req) else $error("request without global enable");
  AST_IRQ_GATE: assert property (en_sh == 4'h0 &&
    $past(en_sh) == 4'h0 |-> !irq) else $error("irq while masked");
  AST_RESET_OUT: assert property ($rose(rstn) |->
    !pready && !irq && !core_irq_req) else $error("outputs not reset");
endmodule
bind irc_top irc_top_props u_props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .core_irq_req(core_irq_req), .irq(irq));

// >>> verification/irc_core_model.sv
// Partner: processor core entering service on each interrupt request
`timescale 1ns/1ns
module irc_core_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       req,
  input  wire logic [1:0] lat,
  output int              entries
);
  logic in_svc;
  int   wait_n;
  // Slow entry with lat above zero, as a busy core would
  always @(posedge clk) begin
    if (!rstn) begin
      in_svc  <= 1'b0;
      entries <= 0;
      wait_n  <= 0;
    end else if (!req) begin
      in_svc <= 1'b0;
      wait_n <= 0;
    end else if (!in_svc && wait_n >= lat) begin
      in_svc  <= 1'b1;
      entries <= entries + 1;
    end else if (!in_svc) begin
      wait_n <= wait_n + 1;
    end
  end
endmodule

// >>> verification/tb_mcu_interrupt_request_control.sv
// Testbench: registers, edges, events and gating of the interrupt block
`timescale 1ns/1ns
module tb_mcu_interrupt_request_control
  import irc_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic        core_irq_req, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_d, seed;
  logic [1:0]  ext_pin, lat;
  logic [13:0] ev, e14;
  int          fails, tests_run, entries, c0, m[10], msk[7];
  int          ord[7] = '{0, 1, 3, 4, 5, 6, 2};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  irc_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_pin(ext_pin),
    .time_base_evt(ev[1:0]), .serial_iface_evt(ev[2]),
    .serial_port_evt(ev[3]), .compact_timer_evt(ev[5:4]),
    .std_timer_evt(ev[7:6]), .periodic_timer_evt(ev[11:8]),
    .low_voltage_evt(ev[12]), .nvm_data_evt(ev[13]),
    .core_irq_req(core_irq_req), .irq(irq));
  irc_core_model u_core (.clk(clk), .rstn(rstn), .req(core_irq_req),
    .lat(lat), .entries(entries));
  // ------
  // Tasks
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Idle cycle after each transfer keeps psel to one change per edge
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    // No cycle count assumed, the watchdog ends a hung wait
    do begin
      tick(1);
    end while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    if (a < ADDR_STATUS) m[a[7:2]] = d & msk[a[7:2]];
  endtask
  task automatic rd(input logic [7:0] a, input int e);
    apb(1'b0, a, 0);
    chk(rd_d, e);
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, ext_pin, ev} = '0;
    {fails, tests_run} = '0;
    lat = 2'h2;
    seed = 32'h0526_df00;
    m = '{default: 0};
    msk = '{MASK_EDGE_SEL, MASK_CTRL0, MASK_FULL, MASK_CTRL2, MASK_FULL,
      MASK_FULL, MASK_HALF};
    tick(4);
    rstn <= 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 0);
    rd(8'h28, 0);
    chk(32'(rd_e), 1);
    for (int k = 0; k < 7; k++) begin
      wr(8'(4 * ord[k]), int'(xs()));
      rd(8'(4 * ord[k]), m[ord[k]]);
      wr(8'(4 * ord[k]), 0);
    end
    for (int p = 0; p < 2; p++) for (int md = 0; md < 4; md++) begin
      wr(ADDR_EDGE_SEL, md << (2 * p));
      ext_pin[p] <= 1'b1;
      tick(5);
      if (md[0]) m[1] |= 1 << (4 + p);
      rd(ADDR_CTRL0, m[1]);
      wr(ADDR_CTRL0, 0);
      ext_pin[p] <= 1'b0;
      tick(5);
      if (md[1]) m[1] |= 1 << (4 + p);
      rd(ADDR_CTRL0, m[1]);
      wr(ADDR_CTRL0, 0);
    end
    wr(ADDR_CLEAR, 15);
    wr(ADDR_ENABLE, 1);
    wr(ADDR_EDGE_SEL, 3);
    ext_pin[0] <= 1'b1;
    tick(5);
    chk(32'(irq), 1);
    rd(ADDR_STATUS, 1);
    wr(ADDR_ENABLE, 0);
    tick(1);
    chk(32'(irq), 0);
    wr(ADDR_ENABLE, 1);
    tick(1);
    chk(32'(irq), 1);
    wr(ADDR_CLEAR, 1);
    tick(1);
    chk(32'(irq), 0);
    rd(ADDR_STATUS, 0);
    c0 = entries;
    wr(ADDR_CTRL0, 3);
    wr(ADDR_EDGE_SEL, 2);
    ext_pin[0] <= 1'b0;
    tick(5);
    chk(32'(core_irq_req), 1);
    // Core with lat 2 enters on its third cycle of request
    tick(3);
    chk(entries, c0 + 1);
    wr(ADDR_CTRL0, 8'h12);
    tick(1);
    chk(32'(core_irq_req), 0);
    lat <= 2'h0;
    wr(ADDR_CTRL0, 8'h13);
    tick(1);
    chk(32'(core_irq_req), 1);
    chk(entries, c0 + 2);
    wr(ADDR_CTRL0, 0);
    repeat (3) begin
      e14 = 14'(xs());
      ev <= e14;
      tick(1);
      ev <= '0;
      tick(4);
      m[1] |= {e14[0], 6'h00};
      m[2] |= {e14[1], 4'h0};
      m[3] |= {e14[3:2], 4'h0};
      m[4] |= {e14[7:4], 4'h0};
      m[5] |= {e14[11:8], 4'h0};
      m[6] |= {e14[13:12], 4'h0};
      for (int i = 1; i < 7; i++) rd(8'(4 * i), m[i]);
    end
    print_verdict();
  end
  // Whole run needs about 500 cycles
  initial begin
    tick(6000);
    fails++;
    print_verdict();
  end
endmodule
